// file: verilog/ces_error_status.sv
// error status register logic of the contactless receiver
// assumes all event inputs are single-cycle pulses on clk
`timescale 1ns/1ps
module ces_error_status
   import ces_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   // host register read port
   input  wire logic       reg_rd_en,
   input  wire logic [7:0] reg_addr,
   output logic      [7:0] reg_rd_data_ff,
   // command and state
   input  wire logic       cmd_start,
   input  wire logic [3:0] cmd_code,
   input  wire logic [2:0] transceive_state,
   input  wire logic       multi_frame_receive,
   input  wire logic       err_flags_to_fifo,
   input  wire logic       auth_cmd_active,
   input  wire logic       crc_tx_active,
   // memory command result
   input  wire logic       nvm_cmd_done,
   input  wire logic       nvm_cmd_fail,
   // host queue writes
   input  wire logic       host_fifo_wr,
   input  wire logic       fifo_full,
   input  wire logic       fifo_empty,
   input  wire logic       fifo_flush,
   input  wire logic       tx_request,
   // receive path
   input  wire logic       rx_sof_valid,
   input  wire logic       rx_bit_strobe,
   input  wire logic       rx_byte_ready,
   input  wire logic       rx_frame_end,
   input  wire logic       rx_collision,
   input  wire logic       rx_coll_in_eof,
   input  wire logic       rx_stop_bit_err,
   input  wire logic       rx_sof_err,
   input  wire logic       rx_count_err,
   input  wire logic       rx_parity_err,
   input  wire logic       rx_crc_err,
   input  wire logic       disturbance_suppression,
   input  wire logic       collision_as_integrity_error,
   // results
   output logic      [7:0] error_flags,
   output logic            error_irq_flag_ff,
   output logic            receive_done_irq_ff,
   output logic            receive_decoder_en_ff,
   output logic            rx_stop_ff,
   output logic            rx_byte_commit_ff,
   output logic            fifo_wr_commit_ff,
   output logic      [7:0] collision_position_reg_ff
);

   logic       [7:0] flag_set;
   logic       [7:0] flag_clr;
   logic       [7:0] flags;
   logic       [6:0] bit_pos;
   logic             frame_short;
   logic             frame_drop;
   logic             wr_illegal;
   logic             coll_ok;
   logic             prot_evt;
   logic             integ_evt;
   logic             rx_clr;
   logic             wait_entry;
   logic             coll_seen_ff;
   logic [3:0]       cur_cmd_ff;
   ces_state_t       state;
   ces_state_t       prev_state_ff;

   assign state       = ces_state_t'(transceive_state);
   assign error_flags = flags;

   // ----------------------------------------------------------------
   // frame length and flag storage
   // ----------------------------------------------------------------
   ces_frame_check u_frame (
      .clk                     (clk),
      .resetn                  (resetn),
      .rx_sof_valid            (rx_sof_valid),
      .rx_bit_strobe           (rx_bit_strobe),
      .rx_frame_end            (rx_frame_end),
      .rx_abort                (prot_evt),
      .disturbance_suppression (disturbance_suppression),
      .bit_pos                 (bit_pos),
      .frame_short             (frame_short),
      .frame_drop              (frame_drop)
   );

   ces_flag_bank u_flags (
      .clk      (clk),
      .resetn   (resetn),
      .set_i    (flag_set),
      .clr_i    (flag_clr),
      .flags_ff (flags)
   );

   // ----------------------------------------------------------------
   // command tracking
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur_cmd_ff <= 4'h0;
      end else if (cmd_start) begin
         cur_cmd_ff <= cmd_code;
      end
   end

   // previous state, for wait-for-data entry
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prev_state_ff <= CES_ST_IDLE;
      end else begin
         prev_state_ff <= state;
      end
   end

   // ----------------------------------------------------------------
   // event decode
   // ----------------------------------------------------------------
   assign wait_entry = (state == CES_ST_WAITDAT) &&
                       (prev_state_ff != CES_ST_WAITDAT) &&
                       (cur_cmd_ff == CES_CMD_TRANSCEIVE);
   assign rx_clr     = (cmd_start && cmd_code == CES_CMD_RECEIVE) ||
                       wait_entry;
   assign wr_illegal = crc_tx_active || auth_cmd_active ||
                       (state == CES_ST_RXWAIT) ||
                       (state == CES_ST_WAITDAT) ||
                       (state == CES_ST_RX);
   assign coll_ok    = rx_collision && !rx_coll_in_eof;
   assign prot_evt   = rx_stop_bit_err || rx_sof_err || rx_count_err;
   assign integ_evt  = rx_parity_err || rx_crc_err ||
                       (coll_ok && collision_as_integrity_error);

   // set terms
   always_comb begin
      flag_set              = 8'h00;
      flag_set[CES_B_NVM]   = nvm_cmd_done && nvm_cmd_fail;
      flag_set[CES_B_WRV]   = host_fifo_wr && wr_illegal;
      flag_set[CES_B_OVF]   = host_fifo_wr && fifo_full;
      flag_set[CES_B_SHORT] = frame_short;
      flag_set[CES_B_EMPTY] = tx_request && fifo_empty;
      flag_set[CES_B_COLL]  = coll_ok;
      flag_set[CES_B_PROT]  = prot_evt;
      flag_set[CES_B_INTEG] = integ_evt;
   end

   // clear terms; a set in the same cycle still wins
   always_comb begin
      flag_clr            = rx_clr ? CES_RX_CLR : 8'h00;
      flag_clr[CES_B_NVM] = nvm_cmd_done && !nvm_cmd_fail;
      flag_clr[CES_B_WRV] = multi_frame_receive ? err_flags_to_fifo
                                                : cmd_start;
      flag_clr[CES_B_OVF] = fifo_flush;
      flag_clr[CES_B_EMPTY] = cmd_start;
   end

   // ----------------------------------------------------------------
   // host queue write gating
   // ----------------------------------------------------------------
   // a full queue keeps its bytes; overflow blocks later writes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fifo_wr_commit_ff <= 1'b0;
      end else begin
         fifo_wr_commit_ff <= host_fifo_wr && !fifo_full &&
                              !flags[CES_B_OVF];
      end
   end

   // ----------------------------------------------------------------
   // receive path control
   // ----------------------------------------------------------------
   // byte that meets a protocol error, and all after it, is withheld
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_byte_commit_ff <= 1'b0;
      end else begin
         rx_byte_commit_ff <= rx_byte_ready && !prot_evt &&
                              receive_decoder_en_ff;
      end
   end

   // protocol error stops reception at once
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_stop_ff <= 1'b0;
      end else begin
         rx_stop_ff <= prot_evt;
      end
   end

   // decoder stays on for dropped frames, off after protocol error
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         receive_decoder_en_ff <= 1'b1;
      end else if (prot_evt) begin
         receive_decoder_en_ff <= 1'b0;
      end else if (rx_clr || rx_sof_valid) begin
         receive_decoder_en_ff <= 1'b1;
      end
   end

   // receive done pulse, suppressed for dropped frames
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         receive_done_irq_ff <= 1'b0;
      end else begin
         receive_done_irq_ff <= rx_frame_end && !frame_drop;
      end
   end

   // ----------------------------------------------------------------
   // first collision position
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         coll_seen_ff              <= 1'b0;
         collision_position_reg_ff <= CES_COLL_RESET;
      end else if (coll_ok && !coll_seen_ff) begin
         coll_seen_ff <= 1'b1;
         collision_position_reg_ff[CES_B_CPVAL] <= (bit_pos < CES_POS_LIM);
         collision_position_reg_ff[6:0]         <= bit_pos;
      end else if (rx_clr) begin
         coll_seen_ff              <= 1'b0;
         collision_position_reg_ff <= CES_COLL_RESET;
      end
   end

   // ----------------------------------------------------------------
   // error interrupt flag and register read
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         error_irq_flag_ff <= 1'b0;
      end else begin
         error_irq_flag_ff <= |(flags & CES_IRQ_MASK);
      end
   end

   // reads have no side effect on the flags
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rd_data_ff <= CES_RD_ZERO;
      end else if (reg_rd_en) begin
         unique case (reg_addr)
            CES_ADDR_ERROR: reg_rd_data_ff <= flags;
            CES_ADDR_COLL:  reg_rd_data_ff <= collision_position_reg_ff;
            default:        reg_rd_data_ff <= CES_RD_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking ast_cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   AST_NVM_FAIL:
      assert property (nvm_cmd_done && nvm_cmd_fail |=> flags[CES_B_NVM] [*2])
      else $error("memory command failure not flagged");

   AST_WRV_SET:
      assert property (host_fifo_wr && (state == CES_ST_RX) |=> flags[CES_B_WRV])
      else $error("illegal queue write not flagged");

   AST_WRV_CLR:
      assert property (cmd_start && !multi_frame_receive && !(host_fifo_wr && wr_illegal)
                       |=> !flags[CES_B_WRV])
      else $error("write violation not cleared at command start");

   AST_WRV_MULTI:
      assert property (multi_frame_receive && flags[CES_B_WRV] && !err_flags_to_fifo
                       |=> flags[CES_B_WRV])
      else $error("write violation cleared before error flags stored");

   AST_OVF_SET:
      assert property (host_fifo_wr && fifo_full |=> flags[CES_B_OVF] && !fifo_wr_commit_ff)
      else $error("overflow not flagged or full queue written");

   AST_OVF_DISCARD:
      assert property (flags[CES_B_OVF] && host_fifo_wr |=> !fifo_wr_commit_ff)
      else $error("write accepted while overflow set");

   AST_DROP_NO_IRQ:
      assert property (frame_drop |=> !receive_done_irq_ff &&
                       $stable(receive_decoder_en_ff))
      else $error("dropped frame raised receive done");

   AST_RX_CLEAR:
      assert property (rx_clr && !coll_ok && !prot_evt && !integ_evt && !frame_short
                       |=> (flags & CES_RX_CLR) == 8'h00)
      else $error("receive error flags not cleared");

   AST_EMPTY_TX:
      assert property (tx_request && fifo_empty |=> flags[CES_B_EMPTY])
      else $error("empty transmit not flagged");

   AST_EOF_COLL:
      assert property (rx_collision && rx_coll_in_eof && !flags[CES_B_COLL]
                       |=> !flags[CES_B_COLL])
      else $error("end-of-frame collision flagged");

   AST_PROT_STOP:
      assert property (prot_evt |=> flags[CES_B_PROT] && rx_stop_ff &&
                       !receive_decoder_en_ff)
      else $error("protocol error did not stop reception");

   AST_PROT_WITHHOLD:
      assert property (prot_evt && rx_byte_ready |=> !rx_byte_commit_ff)
      else $error("byte committed on protocol error");

   AST_INTEG_CONT:
      assert property (rx_parity_err && !prot_evt |=> flags[CES_B_INTEG] && !rx_stop_ff)
      else $error("integrity error not flagged or reception stopped");

   AST_COLL_INTEG:
      assert property (coll_ok && collision_as_integrity_error
                       |=> flags[CES_B_INTEG] && flags[CES_B_COLL])
      else $error("collision did not raise integrity error");

   AST_ERR_IRQ:
      assert property (##1 error_irq_flag_ff == |($past(flags) & CES_IRQ_MASK))
      else $error("error interrupt flag mismatch");

   COV_OVERFLOW:  cover property (host_fifo_wr && fifo_full ##1 host_fifo_wr);
   COV_SHORT:     cover property (frame_short ##1 !receive_done_irq_ff);
   COV_WAIT_DATA: cover property (wait_entry ##[1:20] rx_frame_end);
   COV_PROT:      cover property (prot_evt && rx_byte_ready);

endmodule

// file: include/ces_pkg.sv
// package for the contactless error status block
// assumes one 125 MHz clock and a host register read port
// Function
// - set nvm_cmd_error in bit 7 when the last memory command failed
// - set queue_write_violation in bit 6 on illegal host queue writes
// - clear queue_write_violation when a new contactless command starts
// - with multi-frame receive, clear it after error flags reach the queue
// - set queue_overflow_flag in bit 5 on write to full queue, keep data
// - while overflow is set, discard every further queue write
// - set short_frame_error in bit 4 when valid start has under 4 bits
// - drop frames under 4 bits, keep decoder enabled, no receive-done flag
// - with disturbance suppression, drop frames under 3 bytes the same way
// - clear bits 4,2,1,0 at receive start or transceive wait-for-data entry
// - set empty_transmit_error in bit 3 when sending from an empty queue
// - set collision_detected in bit 2 and record first collision position
// - ignore collisions lying inside the end-of-frame symbol
// - set protocol_error_flag in bit 1 on bad stop, start or count; stop rx
// - on protocol error, keep the last received byte out of the queue
// - set integrity_error_flag in bit 0 on parity or crc error, keep receiving
// - with collision_as_integrity_error set, collisions also set bit 0
// - raise error_irq_flag while bits 6,5,3,1 or 0 are set
// - transceive_state codes: rx wait 101, wait for data 110, receiving 111
package ces_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] CES_ADDR_ERROR = 8'h0A;
   localparam logic [7:0] CES_ADDR_COLL  = 8'h0D;
   localparam logic [7:0] CES_ERR_RESET  = 8'h00;
   localparam logic [7:0] CES_COLL_RESET = 8'h00;
   localparam logic [7:0] CES_RD_ZERO    = 8'h00;

   // ----------------------------------------------------------------
   // error and collision register field positions
   // ----------------------------------------------------------------
   localparam int CES_B_NVM   = 7;
   localparam int CES_B_WRV   = 6;
   localparam int CES_B_OVF   = 5;
   localparam int CES_B_SHORT = 4;
   localparam int CES_B_EMPTY = 3;
   localparam int CES_B_COLL  = 2;
   localparam int CES_B_PROT  = 1;
   localparam int CES_B_INTEG = 0;
   localparam int CES_B_CPVAL = 7;

   // bits that feed the error interrupt flag
   localparam logic [7:0] CES_IRQ_MASK  = 8'h6B;
   // bits cleared by a receive start
   localparam logic [7:0] CES_RX_CLR    = 8'h17;

   // ----------------------------------------------------------------
   // frame length limits
   // ----------------------------------------------------------------
   localparam logic [6:0] CES_MIN_BITS  = 7'h04;
   localparam logic [6:0] CES_MIN_EMD   = 7'h18;
   localparam logic [6:0] CES_BIT_MAX   = 7'h7F;
   localparam logic [6:0] CES_POS_LIM   = 7'h40;

   // ----------------------------------------------------------------
   // transceive state codes and command codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CES_ST_IDLE    = 3'h0,
      CES_ST_TXWAIT  = 3'h1,
      CES_ST_TX      = 3'h3,
      CES_ST_UNUSED  = 3'h4,
      CES_ST_RXWAIT  = 3'h5,
      CES_ST_WAITDAT = 3'h6,
      CES_ST_RX      = 3'h7
   } ces_state_t;

   localparam logic [3:0] CES_CMD_RECEIVE    = 4'h5;
   localparam logic [3:0] CES_CMD_TRANSCEIVE = 4'h7;

endpackage

// file: verilog/ces_flag_bank.sv
// sticky flag bank, one set and one clear per bit
// assumes set and clear are one-cycle pulses from the same clock
`timescale 1ns/1ps
module ces_flag_bank
   import ces_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [7:0] set_i,
   input  wire logic [7:0] clr_i,
   output logic      [7:0] flags_ff
);

   // ----------------------------------------------------------------
   // per-bit flag cells
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         // set wins over a clear in the same cycle
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               flags_ff[gi] <= CES_ERR_RESET[gi];
            end else if (set_i[gi]) begin
               flags_ff[gi] <= 1'b1;
            end else if (clr_i[gi]) begin
               flags_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate

endmodule

// file: verilog/ces_frame_check.sv
// received frame length tracker
// assumes one bit strobe per decoded data bit between start and end
`timescale 1ns/1ps
module ces_frame_check
   import ces_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       rx_sof_valid,
   input  wire logic       rx_bit_strobe,
   input  wire logic       rx_frame_end,
   input  wire logic       rx_abort,
   input  wire logic       disturbance_suppression,
   output logic      [6:0] bit_pos,
   output logic            frame_short,
   output logic            frame_drop
);

   logic       in_frame_ff;
   logic [6:0] bits_ff;

   // ----------------------------------------------------------------
   // frame window and saturating bit counter
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         in_frame_ff <= 1'b0;
      end else if (rx_sof_valid) begin
         in_frame_ff <= 1'b1;
      end else if (rx_frame_end || rx_abort) begin
         in_frame_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bits_ff <= 7'h00;
      end else if (rx_sof_valid) begin
         bits_ff <= 7'h00;
      end else if (in_frame_ff && rx_bit_strobe && bits_ff != CES_BIT_MAX) begin
         bits_ff <= bits_ff + 7'h01;
      end
   end

   // ----------------------------------------------------------------
   // length verdict at the end of the frame
   // ----------------------------------------------------------------
   assign bit_pos     = bits_ff;
   assign frame_short = rx_frame_end && in_frame_ff && (bits_ff < CES_MIN_BITS);
   assign frame_drop  = frame_short ||
                        (rx_frame_end && in_frame_ff && disturbance_suppression &&
                         (bits_ff < CES_MIN_EMD));

endmodule

// file: verification/ces_tag_model.sv
// tag side model: sends one frame of n data bits per go pulse
// assumes go is a one-cycle pulse on clk from the bench
`timescale 1ns/1ps
module ces_tag_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [6:0] n,
   output logic            sof,
   output logic            bit_stb,
   output logic            fend
);
   // frame sequencer, strobes idle low between frames
   initial begin
      {sof, bit_stb, fend} = 3'h0;
      forever begin
         do @(posedge clk); while (!go);
         sof <= 1'b1;
         @(posedge clk);
         sof <= 1'b0;
         // empty frame goes straight to its end, strobe never touched
         if (n != 7'h00) begin
            bit_stb <= 1'b1;
            repeat (n) @(posedge clk);
            bit_stb <= 1'b0;
         end
         fend <= 1'b1;
         @(posedge clk);
         fend <= 1'b0;
      end
   end
endmodule

// file: verification/contactless_error_status_tb.sv
// self-checking bench for the error status block
// assumes ces_pkg and the tag model are compiled first
`timescale 1ns/1ps
module contactless_error_status_tb;
   import ces_pkg::*;
   logic clk = 1'b0, resetn = 1'b0, rde = 1'b0, go = 1'b0, sd = 1'b0, fail = 1'b0;
   logic full = 1'b0, empty = 1'b0, mfr = 1'b0, auth = 1'b0, crct = 1'b0, dsup = 1'b0;
   logic cai = 1'b0, ceof = 1'b0, irq, dn, den, stp, bcm, wcm, sof, bs, fe;
   logic [12:0] ev = 13'h0000;
   logic [7:0] ra = 8'h00, rdd, fl, cpos;
   logic [6:0] fn = 7'h00;
   logic [3:0] code = 4'h0;
   logic [2:0] st = 3'h0;
   int m = 0, error_cnt = 0, n_compared = 0;
   ces_error_status uut (.clk(clk), .resetn(resetn), .reg_rd_en(rde), .reg_addr(ra),
      .reg_rd_data_ff(rdd), .cmd_start(ev[10]), .cmd_code(code), .transceive_state(st),
      .multi_frame_receive(mfr), .err_flags_to_fifo(ev[11]), .auth_cmd_active(auth),
      .crc_tx_active(crct), .nvm_cmd_done(ev[0]), .nvm_cmd_fail(fail),
      .host_fifo_wr(ev[1]), .fifo_full(full), .fifo_empty(empty), .fifo_flush(ev[2]),
      .tx_request(ev[3]), .rx_sof_valid(sof), .rx_bit_strobe(bs), .rx_byte_ready(ev[12]),
      .rx_frame_end(fe), .rx_collision(ev[4]), .rx_coll_in_eof(ceof),
      .rx_stop_bit_err(ev[5]), .rx_sof_err(ev[6]), .rx_count_err(ev[7]),
      .rx_parity_err(ev[8]), .rx_crc_err(ev[9]), .disturbance_suppression(dsup),
      .collision_as_integrity_error(cai), .error_flags(fl), .error_irq_flag_ff(irq),
      .receive_done_irq_ff(dn), .receive_decoder_en_ff(den), .rx_stop_ff(stp),
      .rx_byte_commit_ff(bcm), .fifo_wr_commit_ff(wcm), .collision_position_reg_ff(cpos));
   ces_tag_model tag (.clk(clk), .go(go), .n(fn), .sof(sof), .bit_stb(bs), .fend(fe));
   // clock and sticky receive-done capture
   always #4 clk = ~clk;
   always @(posedge clk) sd <= go ? 1'b0 : (sd | dn);
   // compare and report
   task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one-cycle event pulses, then model update
   task automatic pulse(logic [12:0] v, int s, int c);
      @(posedge clk) ev <= v;
      @(posedge clk) ev <= 13'h0000;
      #1 m = (m & ~c) | s;
   endtask
   task automatic rd(logic [7:0] a);
      @(posedge clk) begin rde <= 1'b1; ra <= a; end
      @(posedge clk) rde <= 1'b0;
      #1;
   endtask
   task automatic frm(int n, int s);
      @(posedge clk) begin go <= 1'b1; fn <= 7'(n); end
      @(posedge clk) go <= 1'b0;
      repeat (n + 4) @(posedge clk);
      #1 m = m | s;
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // watchdog, far beyond the expected run
   initial begin
      #100000;
      error_cnt++;
      stop_test();
   end
   // main sequence
   initial begin
      void'($urandom(82996));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk) #1;
      chk("fl", fl, 8'h00);
      chk("den", den, 8'h01);
      @(posedge clk) fail <= 1'b1;
      pulse(13'h0001, 'h80, 0);
      rd(CES_ADDR_ERROR);
      chk("rd", rdd, m[7:0]);
      rd(CES_ADDR_ERROR);
      chk("rd", rdd, m[7:0]);
      chk("irq", irq, 8'h00);
      rd(8'h33);
      chk("rd", rdd, 8'h00);
      @(posedge clk) fail <= 1'b0;
      pulse(13'h0001, 0, 'h80);
      $display("memory error test done");
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) begin st <= (i < 3) ? 3'(5 + i) : 3'h0; auth <= (i == 3); end
         @(posedge clk) crct <= (i == 4);
         pulse(13'h0002, 'h40, 0);
         chk("wc", wcm, 8'h01);
         chk("fl", fl, m[7:0]);
         @(posedge clk) begin st <= 3'h0; auth <= 1'b0; crct <= 1'b0; end
         pulse(13'h0400, 0, 'h48);
         chk("fl", fl, m[7:0]);
      end
      @(posedge clk) begin mfr <= 1'b1; st <= 3'h7; end
      pulse(13'h0002, 'h40, 0);
      @(posedge clk) st <= 3'h0;
      pulse(13'h0400, 0, 'h08);
      chk("fl", fl, m[7:0]);
      pulse(13'h0800, 0, 'h40);
      chk("fl", fl, m[7:0]);
      @(posedge clk) begin mfr <= 1'b0; full <= 1'b1; end
      pulse(13'h0002, 'h20, 0);
      chk("wc", wcm, 8'h00);
      @(posedge clk) full <= 1'b0;
      pulse(13'h0002, 0, 0);
      chk("wc", wcm, 8'h00);
      chk("irq", irq, 8'h01);
      pulse(13'h0004, 0, 'h20);
      pulse(13'h0002, 0, 0);
      chk("wc", wcm, 8'h01);
      @(posedge clk) empty <= 1'b1;
      pulse(13'h0008, 'h08, 0);
      chk("fl", fl, m[7:0]);
      $display("queue test done");
      @(posedge clk) begin empty <= 1'b0; ceof <= 1'b1; end
      pulse(13'h0010, 0, 0);
      chk("fl", fl, m[7:0]);
      @(posedge clk) begin ceof <= 1'b0; cai <= 1'b1; end
      pulse(13'h0010, 'h05, 0);
      chk("fl", fl, m[7:0]);
      rd(CES_ADDR_COLL);
      chk("coll", rdd, 8'h80);
      chk("cpos", cpos, 8'h80);
      pulse(13'h1300, 'h01, 0);
      chk("bcm", bcm, 8'h01);
      chk("den", den, 8'h01);
      for (int i = 5; i < 8; i++) begin
         pulse(13'h1000 | (13'h0001 << i), 'h02, 0);
         chk("stp", stp, 8'h01);
         chk("bcm", bcm, 8'h00);
         chk("fl", fl, m[7:0]);
      end
      @(posedge clk) code <= CES_CMD_RECEIVE;
      pulse(13'h0400, 0, 'h5F);
      chk("fl", fl, m[7:0]);
      pulse(13'h0110, 'h05, 0);
      @(posedge clk) code <= CES_CMD_TRANSCEIVE;
      pulse(13'h0400, 0, 'h48);
      chk("fl", fl, m[7:0]);
      @(posedge clk) st <= 3'h6;
      repeat (2) @(posedge clk);
      #1 m = m & ~'h17;
      chk("fl", fl, m[7:0]);
      @(posedge clk) st <= 3'h0;
      $display("receive error test done");
      for (int k = 0; k < 4; k++) begin
         frm($urandom % 4, 'h10);
         chk("done", sd, 8'h00);
         chk("fl", fl, m[7:0]);
         chk("den", den, 8'h01);
         frm(4 + $urandom % 60, 0);
         chk("done", sd, 8'h01);
      end
      @(posedge clk) dsup <= 1'b1;
      frm(4 + $urandom % 20, 0);
      chk("done", sd, 8'h00);
      frm(24, 0);
      chk("done", sd, 8'h01);
      $display("frame test done");
      // mid-run reset with short_frame_error still set and collision position already cleared
      @(posedge clk) resetn <= 1'b0;
      @(posedge clk) resetn <= 1'b1;
      @(posedge clk) #1 m = 0;
      chk("fl", fl, m[7:0]);
      chk("cpos", cpos, 8'h00);
      chk("irq", irq, 8'h00);
      chk("den", den, 8'h01);
      $display("reset test done");
      stop_test();
   end
endmodule
